/* core/cfg_hdr_pkg.sv */
// Constants and types shared by the configuration header register bank
package cfg_hdr_pkg;

    // ====================================================================
    // Types
    // ====================================================================
    typedef logic [31:0] dword_t;
    typedef logic [7:0]  byte_t;
    typedef logic [3:0]  pci_cmd_t;

    // Kind of master read command picked from the transfer length
    typedef enum logic [1:0]
    {
        READ_SINGLE,
        READ_LINE,
        READ_MULTIPLE
    } read_kind_e;

    // ====================================================================
    // Configuration offsets (byte addresses, dword aligned)
    // ====================================================================
    localparam byte_t OFS_CLASS_REVISION   = 8'h08;
    localparam byte_t OFS_CACHELINE_LAT    = 8'h0C;
    localparam byte_t OFS_WINDOW_BASE      = 8'h10;
    localparam byte_t OFS_IRQ_GRANT_LAT    = 8'h3C;

    // ====================================================================
    // Fixed field values
    // ====================================================================
    localparam byte_t CLASS_BASE_NETWORK   = 8'h02;
    localparam byte_t CLASS_SUB_OTHER      = 8'h80;
    localparam byte_t CLASS_PROG_NONE      = 8'h00;
    // Revision value is arbitrary, not taken from any real part
    localparam byte_t REVISION_CODE        = 8'h0A;
    localparam logic [6:0] HEADER_LAYOUT_STD = 7'h00;
    localparam logic MULTI_FUNCTION_NONE   = 1'b0;
    localparam byte_t HEADER_RESERVED_VAL  = 8'h00;
    localparam byte_t IRQ_PIN_INTA         = 8'h01;
    localparam byte_t MIN_BURST_PERIOD_VAL = 8'h05;
    localparam byte_t MAX_LATENCY_VAL      = 8'h0F;

    // ====================================================================
    // Base address register layout
    // ====================================================================
    localparam int    WINDOW_BASE_LSB      = 12;
    localparam int    WINDOW_BASE_WIDTH    = 20;
    localparam logic  IO_SPACE_IND_VAL     = 1'b0;
    localparam logic [1:0] PLACEMENT_ANY32 = 2'b00;
    localparam logic  PREFETCHABLE_VAL     = 1'b0;
    localparam logic [7:0] BASE_LOW_ZERO   = 8'h00;

    // ====================================================================
    // Reset values of writable fields
    // ====================================================================
    localparam byte_t CACHELINE_SIZE_RST   = 8'h00;
    localparam byte_t LATENCY_TIMER_RST    = 8'h00;
    localparam byte_t IRQ_ROUTING_RST      = 8'h00;
    localparam logic [19:0] WINDOW_BASE_RST = 20'h0_0000;
    localparam dword_t DWORD_ZERO          = 32'h0000_0000;

    // ====================================================================
    // PCI master read command encodings
    // ====================================================================
    localparam pci_cmd_t CMD_MEM_READ      = 4'h6;
    localparam pci_cmd_t CMD_MEM_READ_LINE = 4'hE;
    localparam pci_cmd_t CMD_MEM_READ_MULT = 4'hC;
    localparam logic [15:0] XFER_ONE_DWORD = 16'h0001;

endpackage : cfg_hdr_pkg

/* core/window_decode.sv */
// Memory window claim decoder for the 4K register window
`timescale 1ns/1ns

module window_decode
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // Memory address phase from the bus
    input  wire logic                  mem_addr_valid,
    input  wire cfg_hdr_pkg::dword_t   mem_addr,
    // Window placement and decode enable
    input  wire logic [19:0]           window_base,
    input  wire logic                  decode_enable,
    // Claim result
    output logic                       hit_q,
    output logic [11:0]                hit_offset_q
);
    import cfg_hdr_pkg::*;

    logic match;

    // ====================================================================
    // Compare the upper 20 address bits against the placed base
    // ====================================================================
    // Decoding off means no claim at all, even on an exact match
    assign match = mem_addr_valid && decode_enable
                   && (mem_addr[31:WINDOW_BASE_LSB] == window_base);

    // Registered claim so the top sees a clean flop output
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hit_q        <= 1'b0;
            hit_offset_q <= 12'h000;
        end
        else
        begin
            hit_q        <= match;
            hit_offset_q <= match ? mem_addr[WINDOW_BASE_LSB-1:0] : 12'h000;
        end
    end

endmodule : window_decode

/* core/pci_config_header_regs.sv */
// Upper PCI type-0 configuration header fields and window decode
//
// Behaviour
// - Class code reads fixed 02H, 80H, 00H
// - Writable cache line size, resets zero
// - Read command chosen from length versus line
// - Writable latency timer in bits 15:8
// - Header layout field reads 00H
// - Multi-function bit and top byte zero
// - Window bit 0 zero: memory space only
// - Placement bits 2:1 read 00B
// - Prefetchable bit reads zero
// - Bits 11:4 zero, 31:12 writable
// - Claim accesses matching upper 20 base bits
// - No claim while memory decoding is off
// - Interrupt routing byte writable, no effect
// - Interrupt pin field reads 01H
// - Minimum burst period reads 05H
// - Maximum latency reads 0FH
// - Read-only bits ignore writes; writables reset zero
// - Memory window answers only when enabled
`timescale 1ns/1ns

module pci_config_header_regs
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Configuration access from the host
    input  wire logic                    cfg_rd,
    input  wire logic                    cfg_wr,
    input  wire cfg_hdr_pkg::byte_t      cfg_offset,
    input  wire logic [3:0]              cfg_be_b,
    input  wire cfg_hdr_pkg::dword_t     cfg_wdata,
    // Configuration answer
    output cfg_hdr_pkg::dword_t          cfg_rdata_q,
    output logic                         cfg_ack_q,
    // Command register memory-space enable bit
    input  wire logic                    memory_space_enable,
    // Memory address phase from the bus
    input  wire logic                    mem_addr_valid,
    input  wire cfg_hdr_pkg::dword_t     mem_addr,
    // Window claim
    output logic                         mem_hit_q,
    output logic [11:0]                  mem_offset_q,
    // Master read command selection
    input  wire logic                    rd_req,
    input  wire logic [15:0]             rd_len,
    output cfg_hdr_pkg::pci_cmd_t        rd_cmd_q,
    output logic                         rd_cmd_valid_q,
    // Field values used by the bus logic
    output cfg_hdr_pkg::byte_t           cacheline_size_q,
    output cfg_hdr_pkg::byte_t           latency_timer_q,
    output logic [19:0]                  window_base_bits_q
);
    import cfg_hdr_pkg::*;

    // ====================================================================
    // Local signals
    // ====================================================================
    byte_t       irq_routing_field_q;
    logic [3:0]  lane_wr;
    logic        sel_class;
    logic        sel_cacheline;
    logic        sel_window;
    logic        sel_irq;
    dword_t      class_word;
    dword_t      cacheline_word;
    dword_t      window_word;
    dword_t      irq_word;
    dword_t      rdata_d;
    read_kind_e  read_kind;
    pci_cmd_t    rd_cmd_d;

    // ====================================================================
    // Offset decode
    // ====================================================================
    // Low two offset bits are ignored: every register is one dword
    assign sel_class     = (cfg_offset[7:2] == OFS_CLASS_REVISION[7:2]);
    assign sel_cacheline = (cfg_offset[7:2] == OFS_CACHELINE_LAT[7:2]);
    assign sel_window    = (cfg_offset[7:2] == OFS_WINDOW_BASE[7:2]);
    assign sel_irq       = (cfg_offset[7:2] == OFS_IRQ_GRANT_LAT[7:2]);

    // ====================================================================
    // Byte lane write strobes
    // ====================================================================
    // Byte enables are active low, as on the bus
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign lane_wr[lane] = cfg_wr && !cfg_be_b[lane];
        end
    endgenerate

    // ====================================================================
    // Cache line size and latency timer
    // ====================================================================
    // Only lanes 0 and 1 hold storage; header layout lanes are constant
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cacheline_size_q <= CACHELINE_SIZE_RST;
        end
        else if (sel_cacheline && lane_wr[0])
        begin
            cacheline_size_q <= cfg_wdata[7:0];
        end
    end

    // Latency timer counts bus clocks; the master logic reads it out
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            latency_timer_q <= LATENCY_TIMER_RST;
        end
        else if (sel_cacheline && lane_wr[1])
        begin
            latency_timer_q <= cfg_wdata[15:8];
        end
    end

    // ====================================================================
    // Window base address
    // ====================================================================
    // Lane 1 carries only bits 15:12; its low nibble is forced zero,
    // which gives the 4K window that sizing software discovers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            window_base_bits_q <= WINDOW_BASE_RST;
        end
        else if (sel_window)
        begin
            if (lane_wr[1])
            begin
                window_base_bits_q[3:0] <= cfg_wdata[15:12];
            end
            if (lane_wr[2])
            begin
                window_base_bits_q[11:4] <= cfg_wdata[23:16];
            end
            if (lane_wr[3])
            begin
                window_base_bits_q[19:12] <= cfg_wdata[31:24];
            end
        end
    end

    // ====================================================================
    // Interrupt routing byte
    // ====================================================================
    // Stored for the host only; nothing in the device looks at it
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_routing_field_q <= IRQ_ROUTING_RST;
        end
        else if (sel_irq && lane_wr[0])
        begin
            irq_routing_field_q <= cfg_wdata[7:0];
        end
    end

    // ====================================================================
    // Read words
    // ====================================================================
    // Fixed class code over the revision byte
    assign class_word = {CLASS_BASE_NETWORK,
                         CLASS_SUB_OTHER,
                         CLASS_PROG_NONE,
                         REVISION_CODE};

    // Reserved byte, single function, standard layout, then storage
    assign cacheline_word = {HEADER_RESERVED_VAL,
                             MULTI_FUNCTION_NONE,
                             HEADER_LAYOUT_STD,
                             latency_timer_q,
                             cacheline_size_q};

    // Writes to the configuration bits have no path into storage
    assign window_word = {window_base_bits_q,
                          BASE_LOW_ZERO,
                          PREFETCHABLE_VAL,
                          PLACEMENT_ANY32,
                          IO_SPACE_IND_VAL};

    // Interrupt pin and grant timing are constants in 250 ns steps
    assign irq_word = {MAX_LATENCY_VAL,
                       MIN_BURST_PERIOD_VAL,
                       IRQ_PIN_INTA,
                       irq_routing_field_q};

    // Read multiplexer; every other header offset reads zero
    always_comb
    begin
        rdata_d = DWORD_ZERO;
        if (sel_class)
        begin
            rdata_d = class_word;
        end
        else if (sel_cacheline)
        begin
            rdata_d = cacheline_word;
        end
        else if (sel_window)
        begin
            rdata_d = window_word;
        end
        else if (sel_irq)
        begin
            rdata_d = irq_word;
        end
        else
        begin
            rdata_d = DWORD_ZERO;
        end
    end

    // ====================================================================
    // Configuration answer
    // ====================================================================
    // Read data are held until the next read so a slow target state
    // machine can pick them up at leisure
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cfg_rdata_q <= DWORD_ZERO;
        end
        else if (cfg_rd)
        begin
            cfg_rdata_q <= rdata_d;
        end
    end

    // One acknowledge pulse per access, read or write
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cfg_ack_q <= 1'b0;
        end
        else
        begin
            cfg_ack_q <= cfg_rd || cfg_wr;
        end
    end

    // ====================================================================
    // Master read command selection
    // ====================================================================
    // A zero cache line size makes every multi-dword read a multiple,
    // which is the safe choice before the host programs the field
    always_comb
    begin
        read_kind = READ_SINGLE;
        if (rd_len <= XFER_ONE_DWORD)
        begin
            read_kind = READ_SINGLE;
        end
        else if (rd_len <= {8'h00, cacheline_size_q})
        begin
            read_kind = READ_LINE;
        end
        else
        begin
            read_kind = READ_MULTIPLE;
        end
    end

    // Map the kind onto the bus command code
    always_comb
    begin
        rd_cmd_d = CMD_MEM_READ;
        case (read_kind)
            READ_SINGLE:   rd_cmd_d = CMD_MEM_READ;
            READ_LINE:     rd_cmd_d = CMD_MEM_READ_LINE;
            READ_MULTIPLE: rd_cmd_d = CMD_MEM_READ_MULT;
            default:       rd_cmd_d = CMD_MEM_READ;
        endcase
    end

    // Command is held after the request; valid pulses for one cycle
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rd_cmd_q       <= CMD_MEM_READ;
            rd_cmd_valid_q <= 1'b0;
        end
        else
        begin
            rd_cmd_valid_q <= rd_req;
            if (rd_req)
            begin
                rd_cmd_q <= rd_cmd_d;
            end
        end
    end

    // ====================================================================
    // Memory window decode
    // ====================================================================
    // Enable gates the claim inside the decoder
    window_decode u_window_decode
    (
        .clk            (clk),
        .rst_b          (rst_b),
        .mem_addr_valid (mem_addr_valid),
        .mem_addr       (mem_addr),
        .window_base    (window_base_bits_q),
        .decode_enable  (memory_space_enable),
        .hit_q          (mem_hit_q),
        .hit_offset_q   (mem_offset_q)
    );

endmodule : pci_config_header_regs

/* testbench/cfg_hdr_props.sv */
// Concurrent checks on the configuration header register bank
`timescale 1ns/1ns

module cfg_hdr_props
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_b,
    // Configuration access
    input wire logic                  cfg_rd,
    input wire logic                  cfg_wr,
    input wire cfg_hdr_pkg::byte_t    cfg_offset,
    input wire logic [3:0]            cfg_be_b,
    input wire cfg_hdr_pkg::dword_t   cfg_rdata_q,
    input wire logic                  cfg_ack_q,
    // Memory decode
    input wire logic                  memory_space_enable,
    input wire logic                  mem_addr_valid,
    input wire cfg_hdr_pkg::dword_t   mem_addr,
    input wire logic                  mem_hit_q,
    input wire logic [11:0]           mem_offset_q,
    // Read command and live fields
    input wire logic                  rd_req,
    input wire logic [15:0]           rd_len,
    input wire cfg_hdr_pkg::pci_cmd_t rd_cmd_q,
    input wire logic                  rd_cmd_valid_q,
    input wire cfg_hdr_pkg::byte_t    cacheline_size_q,
    input wire cfg_hdr_pkg::byte_t    latency_timer_q,
    input wire logic [19:0]           window_base_bits_q
);
    import cfg_hdr_pkg::*;
    // ==================================================================
    // Helpers
    // ==================================================================
    // A write in the same cycle would muddy the read view, so skip it
    logic       rd_only;
    logic [5:0] dw;
    assign rd_only = cfg_rd && !cfg_wr;
    assign dw      = cfg_offset[7:2];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==================================================================
    // Properties
    // ==================================================================
    property p_ack;
        1'b1 |=> cfg_ack_q == $past(cfg_rd || cfg_wr);
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack not one cycle after request");
    property p_class;
        rd_only && dw == 6'h02 |=> cfg_rdata_q[31:8] == 24'h02_8000;
    endproperty
    a_class: assert property (p_class)
        else $error("class code wrong");
    property p_hdr;
        rd_only && dw == 6'h03 |=> cfg_rdata_q ==
            {16'h0000, latency_timer_q, cacheline_size_q};
    endproperty
    a_hdr: assert property (p_hdr)
        else $error("header word wrong");
    property p_base;
        rd_only && dw == 6'h04 |=>
            cfg_rdata_q == {window_base_bits_q, 12'h000};
    endproperty
    a_base: assert property (p_base)
        else $error("base word wrong");
    property p_irq;
        rd_only && dw == 6'h0F |=> cfg_rdata_q[31:8] == 24'h0F_0501;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt word wrong");
    property p_unl;
        rd_only && !(dw inside {6'h02, 6'h03, 6'h04, 6'h0F}) |=>
            cfg_rdata_q == 32'h0000_0000;
    endproperty
    a_unl: assert property (p_unl)
        else $error("unlisted offset not zero");
    property p_hit;
        mem_addr_valid && memory_space_enable &&
            mem_addr[31:12] == window_base_bits_q |=>
            mem_hit_q && mem_offset_q == $past(mem_addr[11:0]);
    endproperty
    a_hit: assert property (p_hit)
        else $error("window claim missed");
    property p_off;
        !memory_space_enable |=> !mem_hit_q && mem_offset_q == 12'h000;
    endproperty
    a_off: assert property (p_off)
        else $error("claim while decoding off");
    property p_cmd;
        rd_req |=> rd_cmd_valid_q && rd_cmd_q ==
            ($past(rd_len) <= 16'h0001 ? CMD_MEM_READ :
             $past(rd_len) <= {8'h00, $past(cacheline_size_q)} ?
             CMD_MEM_READ_LINE : CMD_MEM_READ_MULT);
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("read command wrong");
    property p_hold;
        !cfg_wr |=> $stable(cacheline_size_q) &&
            $stable(latency_timer_q) && $stable(window_base_bits_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("field changed without write");
    property p_lane;
        cfg_wr && dw == 6'h03 && cfg_be_b[0] |=> $stable(cacheline_size_q);
    endproperty
    a_lane: assert property (p_lane)
        else $error("disabled lane written");
endmodule : cfg_hdr_props

bind pci_config_header_regs cfg_hdr_props cfg_hdr_props_inst (.*);

/* testbench/pci_host_model.sv */
// Behavioural host bridge issuing configuration and memory cycles
`timescale 1ns/1ns

module pci_host_model
(
    // Clock
    input  wire logic                clk,
    // Configuration cycle
    output logic                     cfg_rd,
    output logic                     cfg_wr,
    output cfg_hdr_pkg::byte_t       cfg_offset,
    output logic [3:0]               cfg_be_b,
    output cfg_hdr_pkg::dword_t      cfg_wdata,
    input  wire cfg_hdr_pkg::dword_t cfg_rdata_q,
    input  wire logic                cfg_ack_q,
    // Memory address phase
    output logic                     memory_space_enable,
    output logic                     mem_addr_valid,
    output cfg_hdr_pkg::dword_t      mem_addr,
    input  wire logic                mem_hit_q,
    input  wire logic [11:0]         mem_offset_q
);
    import cfg_hdr_pkg::*;
    // ==================================================================
    // Cycles
    // ==================================================================
    // Idle bus at time zero
    initial
    begin
        {cfg_rd, cfg_wr, mem_addr_valid, memory_space_enable} = 4'h0;
        {cfg_offset, cfg_be_b, cfg_wdata, mem_addr} = '0;
    end

    // Strobe is a one-cycle pulse; qualifiers hold until the ack edge
    task automatic cfg(input logic wr, input byte_t ofs,
                       input logic [3:0] be_b, input dword_t wd,
                       output dword_t rd, output logic ack);
        @(posedge clk);
        cfg_rd     <= !wr;
        cfg_wr     <= wr;
        cfg_offset <= ofs;
        cfg_be_b   <= be_b;
        cfg_wdata  <= wd;
        @(posedge clk);
        {cfg_rd, cfg_wr} <= 2'b00;
        @(posedge clk);
        rd  = cfg_rdata_q;
        ack = cfg_ack_q;
        // Released lines must not keep looking valid
        cfg_offset <= ~ofs;
        cfg_wdata  <= ~wd;
    endtask : cfg

    // Window size is the weight of the lowest set base bit
    task automatic size_window(output dword_t size);
        dword_t v;
        logic   a;
        cfg(1'b1, OFS_WINDOW_BASE, 4'h0, 32'hFFFF_FFFF, v, a);
        cfg(1'b0, OFS_WINDOW_BASE, 4'hF, 32'h0000_0000, v, a);
        size = 32'h0000_0000;
        for (int i = 31; i >= 4; i--)
            if (v[i])
                size = 32'h0000_0001 << i;
    endtask : size_window

    // Memory address phase; the enable bit models the command register
    task automatic mem(input logic en, input dword_t addr,
                       output logic hit, output logic [11:0] ofs);
        @(posedge clk);
        memory_space_enable <= en;
        mem_addr_valid      <= 1'b1;
        mem_addr            <= addr;
        @(posedge clk);
        mem_addr_valid <= 1'b0;
        mem_addr       <= ~addr;
        @(posedge clk);
        hit = mem_hit_q;
        ofs = mem_offset_q;
    endtask : mem
endmodule : pci_host_model

/* testbench/tb_top.sv */
// Self-checking bench for the configuration header register bank
`timescale 1ns/1ns

module tb_top;
    import cfg_hdr_pkg::*;
    // ==================================================================
    // Signals and instances
    // ==================================================================
    logic        clk, rst_b, rd_req, ack, hit;
    logic        cfg_rd, cfg_wr, cfg_ack_q, rd_cmd_valid_q;
    logic        memory_space_enable, mem_addr_valid, mem_hit_q;
    logic [15:0] rd_len;
    logic [3:0]  cfg_be_b;
    logic [11:0] mem_offset_q, ofs;
    logic [19:0] window_base_bits_q;
    byte_t       cfg_offset, cacheline_size_q, latency_timer_q;
    dword_t      cfg_wdata, cfg_rdata_q, mem_addr, rd, size;
    pci_cmd_t    rd_cmd_q;
    int          failures = 0;
    int          checks = 0;

    pci_config_header_regs pci_config_header_regs_inst (.*);
    pci_host_model         pci_host_model_inst (.*);

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==================================================================
    // Tasks
    // ==================================================================
    task automatic chk(input dword_t got, input dword_t exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
    endtask : do_reset

    task automatic wr(input byte_t o, input logic [3:0] be, input dword_t d);
        pci_host_model_inst.cfg(1'b1, o, be, d, rd, ack);
        chk({31'h0000_0000, ack}, 32'h0000_0001);
    endtask : wr

    task automatic rdchk(input byte_t o, input dword_t exp);
        pci_host_model_inst.cfg(1'b0, o, 4'hF, 32'h0000_0000, rd, ack);
        chk(rd, exp);
    endtask : rdchk

    task automatic mchk(input logic en, input dword_t a,
                        input logic [12:0] exp);
        pci_host_model_inst.mem(en, a, hit, ofs);
        chk({19'h0_0000, hit, ofs}, {19'h0_0000, exp});
    endtask : mchk

    // Only the bus logic asks for read commands, so the bench drives it
    task automatic cmd(input logic [15:0] len, input pci_cmd_t exp);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_len <= len;
        @(posedge clk);
        rd_req <= 1'b0;
        @(posedge clk);
        chk({28'h000_0000, rd_cmd_q}, {28'h000_0000, exp});
        chk({31'h0000_0000, rd_cmd_valid_q}, 32'h0000_0001);
    endtask : cmd
    // ==================================================================
    // Tests
    // ==================================================================
    // Main sequence; a second reset in mid-run proves the defaults again
    initial
    begin
        rst_b  = 1'b0;
        rd_req = 1'b0;
        rd_len = 16'h0000;
        do_reset();
        rdchk(OFS_CLASS_REVISION, {24'h02_8000, REVISION_CODE});
        rdchk(OFS_CACHELINE_LAT, 32'h0000_0000);
        rdchk(OFS_WINDOW_BASE, 32'h0000_0000);
        rdchk(OFS_IRQ_GRANT_LAT, 32'h0F05_0100);
        wr(OFS_CACHELINE_LAT, 4'h0, 32'hFFFF_FFFF);
        rdchk(OFS_CACHELINE_LAT, 32'h0000_FFFF);
        wr(OFS_CACHELINE_LAT, 4'hE, 32'hFFFF_FF08);
        rdchk(OFS_CACHELINE_LAT, 32'h0000_FF08);
        wr(OFS_CACHELINE_LAT, 4'hD, 32'hFFFF_20FF);
        rdchk(OFS_CACHELINE_LAT, 32'h0000_2008);
        wr(OFS_CACHELINE_LAT, 4'hF, 32'h0000_0000);
        rdchk(OFS_CACHELINE_LAT, 32'h0000_2008);
        chk({24'h00_0000, cacheline_size_q}, 32'h0000_0008);
        chk({24'h00_0000, latency_timer_q}, 32'h0000_0020);
        pci_host_model_inst.size_window(size);
        chk(size, 32'h0000_1000);
        rdchk(OFS_WINDOW_BASE, 32'hFFFF_F000);
        wr(OFS_WINDOW_BASE, 4'h0, 32'hABCD_E123);
        rdchk(OFS_WINDOW_BASE, 32'hABCD_E000);
        chk({12'h000, window_base_bits_q}, 32'h000A_BCDE);
        wr(OFS_IRQ_GRANT_LAT, 4'h0, 32'hFFFF_FFFF);
        rdchk(OFS_IRQ_GRANT_LAT, 32'h0F05_01FF);
        wr(8'h24, 4'h0, 32'hFFFF_FFFF);
        rdchk(8'h24, 32'h0000_0000);
        mchk(1'b1, 32'hABCD_E123, 13'h1123);
        mchk(1'b1, 32'hABCD_F123, 13'h0000);
        mchk(1'b0, 32'hABCD_E123, 13'h0000);
        cmd(16'h0001, CMD_MEM_READ);
        cmd(16'h0008, CMD_MEM_READ_LINE);
        cmd(16'h0009, CMD_MEM_READ_MULT);
        cmd(16'h0000, CMD_MEM_READ);
        do_reset();
        rdchk(OFS_CACHELINE_LAT, 32'h0000_0000);
        rdchk(OFS_WINDOW_BASE, 32'h0000_0000);
        rdchk(OFS_IRQ_GRANT_LAT, 32'h0F05_0100);
        // Line size is zero again, so any multi-dword read is a multiple
        cmd(16'h0002, CMD_MEM_READ_MULT);
        test_done();
    end

    // Watchdog well beyond the roughly 120 cycles the tests need
    initial
    begin
        #100000;
        failures++;
        test_done();
    end
endmodule : tb_top
